// [verilog/dac_loader_pkg.sv]
package dac_loader_pkg;

    // ************************************************************
    // Word format and channel map.
    // ************************************************************
    localparam int              CHAN_COUNT = 12;
    localparam int              CODE_W     = 8;
    localparam int              ADDR_W     = 4;
    localparam int              WORD_W     = ADDR_W + CODE_W;
    localparam int              ADDR_MSB   = WORD_W - 1;
    localparam int              ADDR_LSB   = CODE_W;
    localparam int              CODE_MSB   = CODE_W - 1;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 4'hB;
    localparam logic [CODE_W-1:0] MIDSCALE  = 8'h80;
    localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
    localparam logic [WORD_W-1:0] WORD_ZERO = 12'h000;

    // ************************************************************
    // Pin sampler layout.
    // ************************************************************
    localparam int              SYNC_W     = 3;
    localparam logic [SYNC_W-1:0] SYNC_ONES = 3'h7;
    localparam logic [SYNC_W-1:0] SYNC_ZERO = 3'h0;

    typedef enum logic [0:0] {IDLE_ST, SHIFT_ST} link_state_t;

endpackage

// [verilog/twelve_channel_serial_dac_loader.sv]
module twelve_channel_serial_dac_loader
    import dac_loader_pkg::*;
(
    // System.
    input  wire logic                      sys_clk,
    input  wire logic                      rstn,
    input  wire logic                      clk_en,
    // Serial link pins.
    input  wire logic                      serial_clk_pin,
    input  wire logic                      select_n_pin,
    input  wire logic                      serial_in_pin,
    // Control pins.
    input  wire logic                      midscale_preset_n,
    input  wire logic                      power_down_n,
    // Channel codes and reference control.
    output logic [CHAN_COUNT*CODE_W-1:0]   channel_codes,
    output logic [CODE_W-1:0]              channel_out_first,
    output logic [CODE_W-1:0]              channel_out_last,
    output logic                           ref_current_on,
    output logic                           outputs_enabled
);

    // ************************************************************
    // Pin sampling.
    // ************************************************************
    logic [SYNC_W-1:0] sclk_sync_r;
    logic [SYNC_W-1:0] csn_sync_r;
    logic [SYNC_W-1:0] data_sync_r;
    logic [SYNC_W-1:0] rsn_sync_r;
    logic [SYNC_W-1:0] pdn_sync_r;
    logic              sclk_r;
    logic              csn_r;
    logic              rsn_r;
    logic              pdn_r;

    function automatic logic settle(input logic [SYNC_W-1:0] s, input logic prev);
        settle = (s[1] == s[2]) ? s[1] : prev;
    endfunction

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            sclk_sync_r <= SYNC_ONES;
            csn_sync_r  <= SYNC_ONES;
            data_sync_r <= SYNC_ZERO;
            rsn_sync_r  <= SYNC_ONES;
            pdn_sync_r  <= SYNC_ONES;
        end
        else if (clk_en)
        begin
            sclk_sync_r <= {sclk_sync_r[1:0], serial_clk_pin};
            csn_sync_r  <= {csn_sync_r[1:0], select_n_pin};
            data_sync_r <= {data_sync_r[1:0], serial_in_pin};
            rsn_sync_r  <= {rsn_sync_r[1:0], midscale_preset_n};
            pdn_sync_r  <= {pdn_sync_r[1:0], power_down_n};
        end
    end

    // Settled levels follow only when the last two stages agree.
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            sclk_r <= 1'b1;
            csn_r  <= 1'b1;
            rsn_r  <= 1'b1;
            pdn_r  <= 1'b1;
        end
        else if (clk_en)
        begin
            sclk_r <= settle(sclk_sync_r, sclk_r);
            csn_r  <= settle(csn_sync_r, csn_r);
            rsn_r  <= settle(rsn_sync_r, rsn_r);
            pdn_r  <= settle(pdn_sync_r, pdn_r);
        end
    end

    logic sclk_nxt;
    logic csn_nxt;
    logic sclk_rise;
    logic csn_rise;
    assign sclk_nxt  = settle(sclk_sync_r, sclk_r);
    assign csn_nxt   = settle(csn_sync_r, csn_r);
    assign sclk_rise = sclk_nxt && !sclk_r;
    assign csn_rise  = csn_nxt && !csn_r;

    // ************************************************************
    // Serial shift register.
    // ************************************************************
    logic [WORD_W-1:0] shift_r;
    link_state_t       state_r;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            state_r <= IDLE_ST;
        else if (clk_en)
            state_r <= csn_r ? IDLE_ST : SHIFT_ST;
    end

    // MSB enters first, so the oldest of the last twelve bits ends at the top.
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            shift_r <= WORD_ZERO;
        else if (clk_en && state_r == SHIFT_ST && !csn_r && sclk_rise)
            shift_r <= {shift_r[WORD_W-2:0], data_sync_r[2]};
    end

    // ************************************************************
    // Channel latches.
    // ************************************************************
    logic [CODE_W-1:0] latch_r [CHAN_COUNT];
    logic [ADDR_W-1:0] addr;
    logic [CODE_W-1:0] code;
    assign addr = shift_r[ADDR_MSB:ADDR_LSB];
    assign code = shift_r[CODE_MSB:0];

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < CHAN_COUNT; i++)
                latch_r[i] <= CODE_ZERO;
        end
        else if (clk_en)
        begin
            if (!rsn_r)
            begin
                for (int i = 0; i < CHAN_COUNT; i++)
                    latch_r[i] <= MIDSCALE;
            end
            else if (csn_rise && addr <= ADDR_LAST)
                latch_r[addr] <= code;
        end
    end

    // ************************************************************
    // Outputs and shutdown.
    // ************************************************************
    always_comb
    begin
        for (int i = 0; i < CHAN_COUNT; i++)
            channel_codes[i*CODE_W +: CODE_W] = latch_r[i];
    end

    assign channel_out_first = latch_r[0];
    assign channel_out_last  = latch_r[CHAN_COUNT-1];
    assign ref_current_on    = pdn_r;
    assign outputs_enabled   = pdn_r;

    // ************************************************************
    // Checks.
    // ************************************************************
    property p_hold_idle;
        @(posedge sys_clk) disable iff (!rstn)
        (csn_r && clk_en) |=> $stable(shift_r);
    endproperty
    a_hold_idle: assert property (p_hold_idle) else $error("shift moved while idle");

    property p_shift;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && state_r == SHIFT_ST && !csn_r && sclk_rise)
        |=> shift_r == {$past(shift_r[WORD_W-2:0]), $past(data_sync_r[2])};
    endproperty
    a_shift: assert property (p_shift) else $error("bad shift");

    property p_load;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && rsn_r && csn_rise && addr <= ADDR_LAST) |=> latch_r[$past(addr)] == $past(code);
    endproperty
    a_load: assert property (p_load) else $error("latch not loaded");

    property p_first;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && rsn_r && csn_rise && addr == ADDR_W'(0)) |=> channel_out_first == $past(code);
    endproperty
    a_first: assert property (p_first) else $error("channel one map");

    property p_bad_addr;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && rsn_r && addr > ADDR_LAST) |=> $stable(channel_codes);
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("bad address wrote");

    property p_preset;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && !rsn_r) |=> channel_out_first == MIDSCALE && channel_out_last == MIDSCALE;
    endproperty
    a_preset: assert property (p_preset) else $error("preset missed");

    property p_shutdown_keep;
        @(posedge sys_clk) disable iff (!rstn)
        (!pdn_r && !csn_rise && rsn_r) |-> !ref_current_on ##1 $stable(channel_codes);
    endproperty
    a_shutdown_keep: assert property (p_shutdown_keep) else $error("shutdown lost codes");

    property p_no_load_low;
        @(posedge sys_clk) disable iff (!rstn)
        (csn_r == 1'b0 && !csn_rise && rsn_r) |=> $stable(channel_codes);
    endproperty
    a_no_load_low: assert property (p_no_load_low) else $error("load while selected");

endmodule

// [verification/serial_host_model.sv]
// ********
// Host serial port: shifts words out on three wires.
// ********
module serial_host_model;
    timeunit 1ns;
    timeprecision 1ps;

    logic sclk  = 1'b1;
    logic sel_n = 1'b1;
    logic sdata = 1'b0;

    // Sends the low nbits of word, most significant bit first.
    task automatic send(input logic [31:0] word, input int nbits);
        sel_n = 1'b0;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            sclk  = 1'b0;
            sdata = word[i];
            #32 sclk = 1'b1;
            #32;
        end
        sel_n = 1'b1;
        sdata = ~sdata;
        #64;
    endtask

    // Pulses the clock while deselected, with the data line toggling.
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++)
        begin
            sclk  = 1'b0;
            sdata = ~sdata;
            #32 sclk = 1'b1;
            #32;
        end
    endtask
endmodule

// [verification/twelve_channel_serial_dac_loader_tb.sv]
module twelve_channel_serial_dac_loader_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dac_loader_pkg::*;

    // ********
    // Signals, clock and design.
    // ********
    logic              sys_clk = 1'b0;
    logic              rstn = 1'b0;
    logic              clk_en = 1'b1;
    logic              midscale_preset_n = 1'b1;
    logic              power_down_n = 1'b1;
    logic [95:0]       channel_codes;
    logic [CODE_W-1:0] channel_out_first;
    logic [CODE_W-1:0] channel_out_last;
    logic              ref_current_on;
    logic              outputs_enabled;
    int                model[CHAN_COUNT];
    int                n_errors = 0;
    int                samples_checked = 0;
    logic [31:0]       lfsr_r = 32'hD22C;

    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end

    serial_host_model host_i ();

    twelve_channel_serial_dac_loader twelve_channel_serial_dac_loader_i (
        .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
        .serial_clk_pin(host_i.sclk), .select_n_pin(host_i.sel_n),
        .serial_in_pin(host_i.sdata), .midscale_preset_n(midscale_preset_n),
        .power_down_n(power_down_n), .channel_codes(channel_codes),
        .channel_out_first(channel_out_first), .channel_out_last(channel_out_last),
        .ref_current_on(ref_current_on), .outputs_enabled(outputs_enabled));

    // ********
    // Helpers.
    // ********
    function automatic logic [7:0] next_rand();
        lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        return lfsr_r[7:0];
    endfunction

    task automatic check(input logic [113:0] seen, input logic [113:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic check_state(input logic ref_exp);
        logic [95:0]  exp;
        logic [113:0] seen_v;
        @(posedge sys_clk);
        #1;
        foreach (model[k]) exp[k*8 +: 8] = model[k][7:0];
        seen_v = {channel_codes, channel_out_first, channel_out_last, ref_current_on,
                  outputs_enabled};
        check(seen_v, {exp, exp[7:0], exp[95:88], ref_exp, ref_exp});
    endtask

    task automatic load(input logic [3:0] addr, input logic [7:0] code,
                        input logic [3:0] junk, input int nbits);
        host_i.send({16'h0, junk, addr, code}, nbits);
        if (addr <= ADDR_LAST) model[addr] = code;
        check_state(power_down_n);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ********
    // Tests and watchdog.
    // ********
    initial
    begin
        #100000;
        n_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        end_of_test();
    end

    initial
    begin
        foreach (model[k]) model[k] = 0;
        repeat (12) @(posedge sys_clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge sys_clk);
        check_state(1'b1);
        for (int a = 0; a < 16; a++) load(a[3:0], next_rand(), 4'h0, WORD_W);
        $display("test address map done");
        load(4'h3, next_rand(), 4'hC, 16);
        load(4'h2, 8'hA5, 4'h0, WORD_W);
        host_i.idle_clocks(4);
        host_i.send(32'h5A, 8);
        model[5] = 8'h5A;
        check_state(1'b1);
        $display("test long and short words done");
        power_down_n = 1'b0;
        repeat (6) @(posedge sys_clk);
        check_state(1'b0);
        load(4'hB, next_rand(), 4'h0, WORD_W);
        power_down_n = 1'b1;
        repeat (6) @(posedge sys_clk);
        check_state(1'b1);
        $display("test shutdown done");
        midscale_preset_n = 1'b0;
        repeat (6) @(posedge sys_clk);
        foreach (model[k]) model[k] = MIDSCALE;
        check_state(1'b1);
        midscale_preset_n = 1'b1;
        repeat (6) @(posedge sys_clk);
        load(4'h0, next_rand(), 4'h0, WORD_W);
        $display("test preset done");
        clk_en = 1'b0;
        host_i.send(32'h13C, WORD_W);
        clk_en = 1'b1;
        check_state(1'b1);
        $display("test clock enable done");
        end_of_test();
    end
endmodule
